// ===== src/pwr_seq_pkg.sv
package pwr_seq_pkg;

  // ----------------------------------------------------------------
  // Register addresses (9-bit SPI register index)
  // ----------------------------------------------------------------
  localparam logic [8:0] ADDR_VARIANT_SELECT = 9'h002;
  localparam logic [8:0] ADDR_CLOCK_MGMT = 9'h020;
  localparam logic [8:0] ADDR_LOGIC_ENABLE = 9'h022;
  localparam logic [8:0] ADDR_COLUMN_MUX = 9'h028;
  localparam logic [8:0] ADDR_FRONT_END = 9'h030;
  localparam logic [8:0] ADDR_BIAS_ENABLE = 9'h040;
  localparam logic [8:0] ADDR_GENERAL_BIAS = 9'h041;
  localparam logic [8:0] ADDR_FRONT_END_BIAS = 9'h042;
  localparam logic [8:0] ADDR_MUX_BIAS = 9'h043;
  localparam logic [8:0] ADDR_SERIAL_OUT_BIAS = 9'h044;
  localparam logic [8:0] ADDR_SERIAL_TX = 9'h070;
  localparam logic [8:0] ADDR_BLACK_LEVEL = 9'h080;
  localparam logic [8:0] ADDR_BLACK_DEPTH = 9'h081;
  localparam logic [8:0] ADDR_SEQ_MODE = 9'h0c0;
  localparam logic [8:0] ADDR_GAIN = 9'h0cc;
  localparam logic [8:0] ADDR_DUMMY_ROWS = 9'h0e0;
  localparam logic [8:0] ADDR_LATENCY = 9'h0e1;
  localparam logic [8:0] ADDR_SEQ_TUNE_A = 9'h1bf;
  localparam logic [8:0] ADDR_SEQ_TUNE_B = 9'h1c0;
  // Lowest address that is refused in standby one
  localparam logic [8:0] ADDR_STANDBY1_LIMIT = 9'h028;

  // ----------------------------------------------------------------
  // Values that mark completed upload steps
  // ----------------------------------------------------------------
  localparam logic [15:0] VAL_CLK_DIGITAL = 16'h2002;
  localparam logic [15:0] VAL_CLK_ANALOG = 16'h2003;
  localparam logic [15:0] VAL_LOGIC_ON = 16'h0001;
  localparam logic [15:0] VAL_BIAS_ON = 16'h0001;
  localparam logic [15:0] VAL_MUX_ON = 16'h0003;
  localparam logic [15:0] VAL_FRONT_END_ON = 16'h0001;
  localparam logic [15:0] VAL_TX_ON = 16'h0007;
  localparam logic [15:0] VAL_OFF = 16'h0000;
  localparam logic [15:0] VAL_GENERAL_BIAS = 16'h008b;
  localparam logic [15:0] VAL_FRONT_END_BIAS = 16'h53c6;
  localparam logic [15:0] VAL_MUX_BIAS = 16'h0844;
  localparam logic [15:0] VAL_SERIAL_OUT_BIAS = 16'h0086;
  localparam logic [15:0] VAL_BLACK_LEVEL = 16'h4520;
  localparam logic [15:0] VAL_GAIN = 16'h09e5;
  localparam logic [15:0] VAL_DUMMY_ROWS = 16'h3e04;
  localparam logic [15:0] VAL_LATENCY = 16'h6733;
  localparam logic [15:0] VAL_SEQ_TUNE_A = 16'h0bf1;
  localparam logic [15:0] VAL_SEQ_TUNE_B = 16'h0bc3;
  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SEQ_RUN = 0;
  localparam int BIT_SHUTTER = 1;
  localparam int BIT_TRIGGERED = 4;
  localparam int BIT_SLAVE = 5;
  localparam int BIT_SUBSAMPLE = 7;
  localparam int BIT_BINNING = 8;
  localparam int BIT_DEPTH_8 = 13;
  localparam logic [15:0] MODE_FIELD_MASK = 16'h01b2;
  localparam int NUM_RESERVED = 9;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_WAIT_US = 10;
  localparam int RESET_WAIT_CYCLES = (RESET_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_STANDBY1,
    ST_STANDBY_INT,
    ST_STANDBY2,
    ST_IDLE,
    ST_RUNNING
  } power_state_type;

endpackage : pwr_seq_pkg

// ===== src/frame_capture.sv
`timescale 1ns/1ns
module frame_capture
  import pwr_seq_pkg::*;
#(
  parameter int FRAME_CYCLES = 64,
  parameter int OVERHEAD_CYCLES = 8
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic run, // Sequencer run level
  input wire logic rolling, // Rolling shutter select
  input wire logic triggered, // Triggered capture select
  input wire logic slave, // Slave exposure select
  input wire logic trigger, // External trigger level
  output logic capturing, // Frame in progress
  output logic overhead, // Frame overhead period active
  output logic frame_start // Pulse at frame start
);

  typedef enum {CAP_IDLE, CAP_WAIT, CAP_OVERHEAD, CAP_READ} cap_state_type;

  cap_state_type state_reg, state_next;
  logic [15:0] count_reg, count_next;
  logic trig_reg, trig_next;
  logic start_reg, start_next;
  logic rise;
  logic fall;
  logic gated;

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  // Trigger and slave only matter under global shutter
  assign gated = !rolling && (triggered || slave);
  assign rise = trigger && !trig_reg;
  assign fall = !trigger && trig_reg;

  // Next-state logic; a stop request ends the current frame at once
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    trig_next = trigger;
    start_next = 1'b0;
    unique case (state_reg)
      CAP_IDLE: begin
        if (run) begin
          state_next = gated ? CAP_WAIT : CAP_OVERHEAD;
          count_next = 16'(OVERHEAD_CYCLES);
          start_next = !gated;
        end
      end
      CAP_WAIT: begin
        // Slave starts the frame overhead on trigger release, triggered master on rise
        if (!run) begin
          state_next = CAP_IDLE;
        end else if ((slave && fall) || (!slave && rise)) begin
          state_next = CAP_OVERHEAD;
          count_next = 16'(OVERHEAD_CYCLES);
          start_next = 1'b1;
        end
      end
      CAP_OVERHEAD: begin
        if (!run) begin
          state_next = CAP_IDLE;
        end else if (count_reg <= 16'h0001) begin
          state_next = CAP_READ;
          count_next = 16'(FRAME_CYCLES);
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end
      CAP_READ: begin
        if (!run) begin
          state_next = CAP_IDLE;
        end else if (count_reg <= 16'h0001) begin
          state_next = gated ? CAP_WAIT : CAP_OVERHEAD;
          count_next = 16'(OVERHEAD_CYCLES);
          start_next = !gated;
        end else begin
          count_next = count_reg - 16'h0001;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= CAP_IDLE;
      count_reg <= 16'h0000;
      trig_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      trig_reg <= trig_next;
      start_reg <= start_next;
    end
  end

  assign capturing = (state_reg == CAP_OVERHEAD) || (state_reg == CAP_READ);
  assign overhead = (state_reg == CAP_OVERHEAD);
  assign frame_start = start_reg;

endmodule : frame_capture

// ===== src/sensor_power_state_upload_sequencer.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Bit 13 of register 129 selects 8-bit (1) or 10-bit (0) words.
// - Once running, frames follow back to back under free-running master; triggered and slave modes wait for a trigger edge before each frame.
// - Clearing the run bit stops capture and returns the device to idle.
// - Bit 1 of register 192 selects global (0) or rolling (1) shutter.
// - Bit 4 selects triggered capture, global shutter only, reset zero.
// - Bit 5 selects slave exposure, global shutter only, reset zero.
// - Bit 7 enables subsampled readout, reset zero.
// - Bit 8 enables binned readout, reset zero.
// - Idle is entered with clocks and blocks enabled and keeps the frame sequencer stopped; only ANALOG_ON is held, CLOCKS_ON follows the logic enable.
module sensor_power_state_upload_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int FRAME_CYCLES = 64,
  parameter int OVERHEAD_CYCLES = 8
) (
  input wire logic CLK_SYS, // System clock, 100 MHz
  input wire logic ARST_N, // Async reset, active low
  input wire logic WR_EN, // Register write strobe
  input wire logic RD_EN, // Register read strobe
  input wire logic [8:0] ADDR, // Register address
  input wire logic [15:0] WDATA, // Write data
  input wire logic TRIGGER, // External exposure trigger
  output logic [15:0] RDATA, // Read data, registered
  output logic RDATA_VALID, // Read data valid pulse
  output logic WR_REJECT, // Write refused pulse
  output logic [2:0] POWER_STATE, // Current power state
  output logic UPLOAD_READY, // Reset wait elapsed
  output logic CLOCKS_ON, // Internal clocking enabled
  output logic ANALOG_ON, // Analog blocks enabled
  output logic DEPTH_8BIT, // Output word depth select
  output logic ROLLING_SHUTTER, // Rolling shutter active
  output logic TRIGGERED_MODE, // Triggered capture active
  output logic SLAVE_MODE, // Slave exposure active
  output logic SUBSAMPLE_EN, // Subsampled readout
  output logic BINNING_EN, // Binned readout
  output logic CAPTURING, // Frame in progress
  output logic FRAME_OVERHEAD, // Frame overhead period
  output logic FRAME_START // Frame start pulse
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] regs_reg [0:18];
  logic [15:0] regs_next [0:18];
  logic [8:0] addr_tab [0:18];
  logic [18:0] hit;
  logic [4:0] hit_idx;
  logic any_hit;
  power_state_type state_reg, state_next;
  logic [NUM_RESERVED-1:0] resv_reg, resv_next;
  logic [15:0] wait_reg, wait_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic reject_reg, reject_next;
  logic wr_ok;
  logic mode_change;
  logic [15:0] seq_mode;
  logic [15:0] clk_cfg;
  logic [15:0] logic_en;
  logic analog_all;
  logic analog_none;

  assign addr_tab = '{ADDR_VARIANT_SELECT, ADDR_CLOCK_MGMT, ADDR_LOGIC_ENABLE, ADDR_COLUMN_MUX,
                      ADDR_FRONT_END, ADDR_BIAS_ENABLE, ADDR_GENERAL_BIAS, ADDR_FRONT_END_BIAS,
                      ADDR_MUX_BIAS, ADDR_SERIAL_OUT_BIAS, ADDR_SERIAL_TX, ADDR_BLACK_LEVEL,
                      ADDR_BLACK_DEPTH, ADDR_SEQ_MODE, ADDR_GAIN, ADDR_DUMMY_ROWS,
                      ADDR_LATENCY, ADDR_SEQ_TUNE_A, ADDR_SEQ_TUNE_B};

  // Address decode, one comparator per register
  for (genvar i = 0; i < 19; i++) begin : g_dec
    assign hit[i] = (ADDR == addr_tab[i]);
  end

  always_comb begin
    hit_idx = 5'h00;
    for (int k = 0; k < 19; k++) begin
      if (hit[k]) begin
        hit_idx = 5'(k);
      end
    end
  end

  assign any_hit = |hit;
  assign seq_mode = regs_reg[13];
  assign clk_cfg = regs_reg[1];
  assign logic_en = regs_reg[2];
  assign analog_all = (clk_cfg == VAL_CLK_ANALOG) && (regs_reg[5] == VAL_BIAS_ON) &&
                      (regs_reg[3] == VAL_MUX_ON) && (regs_reg[4] == VAL_FRONT_END_ON) &&
                      (regs_reg[10] == VAL_TX_ON);
  assign analog_none = (clk_cfg == VAL_CLK_DIGITAL) && (regs_reg[5] == VAL_OFF) &&
                       (regs_reg[3] == VAL_OFF) && (regs_reg[4] == VAL_OFF) &&
                       (regs_reg[10] == VAL_OFF);

  // Mode fields are locked while running; a write that alters them is refused
  assign mode_change = ((WDATA ^ seq_mode) & MODE_FIELD_MASK) != 16'h0000;
  always_comb begin
    wr_ok = WR_EN && any_hit;
    if (state_reg == ST_STANDBY1 && ADDR >= ADDR_STANDBY1_LIMIT) begin
      wr_ok = 1'b0;
    end
    if (state_reg == ST_RUNNING && ADDR == ADDR_SEQ_MODE && mode_change) begin
      wr_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register file and bus answers
  // ----------------------------------------------------------------
  always_comb begin
    regs_next = regs_reg;
    rdata_next = rdata_reg;
    rvalid_next = RD_EN;
    reject_next = WR_EN && !wr_ok;
    if (wr_ok) begin
      regs_next[hit_idx] = WDATA;
    end
    if (RD_EN) begin
      // Unmapped addresses read as zero
      rdata_next = any_hit ? regs_reg[hit_idx] : 16'h0000;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int k = 0; k < 19; k++) begin
        regs_reg[k] <= RESET_VALUE;
      end
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      regs_reg <= regs_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      reject_reg <= reject_next;
    end
  end

  // ----------------------------------------------------------------
  // Power state tracking
  // ----------------------------------------------------------------
  // Each reserved upload but ADDR_SEQ_TUNE_A (checked in place) sets one flag when the exact value lands; a wrong value clears it
  always_comb begin
    resv_next = resv_reg;
    if (wr_ok) begin
      if (ADDR == ADDR_GENERAL_BIAS) resv_next[0] = (WDATA == VAL_GENERAL_BIAS);
      if (ADDR == ADDR_FRONT_END_BIAS) resv_next[1] = (WDATA == VAL_FRONT_END_BIAS);
      if (ADDR == ADDR_MUX_BIAS) resv_next[2] = (WDATA == VAL_MUX_BIAS);
      if (ADDR == ADDR_SERIAL_OUT_BIAS) resv_next[3] = (WDATA == VAL_SERIAL_OUT_BIAS);
      if (ADDR == ADDR_BLACK_LEVEL) resv_next[4] = (WDATA == VAL_BLACK_LEVEL);
      if (ADDR == ADDR_GAIN) resv_next[5] = (WDATA == VAL_GAIN);
      if (ADDR == ADDR_DUMMY_ROWS) resv_next[6] = (WDATA == VAL_DUMMY_ROWS);
      if (ADDR == ADDR_LATENCY) resv_next[7] = (WDATA == VAL_LATENCY);
      if (ADDR == ADDR_SEQ_TUNE_B) resv_next[8] = (WDATA == VAL_SEQ_TUNE_B);
    end
  end

  // State follows the registers once each write has landed
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_STANDBY1: begin
        if (clk_cfg == VAL_CLK_DIGITAL && logic_en == VAL_LOGIC_ON) begin
          state_next = ST_STANDBY_INT;
        end
      end
      ST_STANDBY_INT: begin
        if (logic_en != VAL_LOGIC_ON) begin
          state_next = ST_STANDBY1;
        end else if (&resv_reg && regs_reg[17] == VAL_SEQ_TUNE_A) begin
          state_next = ST_STANDBY2;
        end
      end
      ST_STANDBY2: begin
        if (logic_en != VAL_LOGIC_ON) begin
          state_next = ST_STANDBY1;
        end else if (analog_all) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (seq_mode[BIT_SEQ_RUN]) begin
          state_next = ST_RUNNING;
        end else if (analog_none) begin
          state_next = ST_STANDBY2;
        end
      end
      ST_RUNNING: begin
        if (!seq_mode[BIT_SEQ_RUN]) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // Reset wait counter: uploads are only advised once it expires
  always_comb begin
    wait_next = wait_reg;
    if (wait_reg != 16'h0000) begin
      wait_next = wait_reg - 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= ST_STANDBY1;
      resv_reg <= '0;
      wait_reg <= 16'(RESET_WAIT_CYCLES);
    end else begin
      state_reg <= state_next;
      resv_reg <= resv_next;
      wait_reg <= wait_next;
    end
  end

  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  frame_capture #(
    .FRAME_CYCLES(FRAME_CYCLES),
    .OVERHEAD_CYCLES(OVERHEAD_CYCLES)
  ) u_capture (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .run(state_next == ST_RUNNING), // Next state keeps capture in step with POWER_STATE
    .rolling(seq_mode[BIT_SHUTTER]),
    .triggered(seq_mode[BIT_TRIGGERED]),
    .slave(seq_mode[BIT_SLAVE]),
    .trigger(TRIGGER),
    .capturing(CAPTURING),
    .overhead(FRAME_OVERHEAD),
    .frame_start(FRAME_START)
  );

  // Outputs straight from registers or decoded from them
  assign RDATA = rdata_reg;
  assign RDATA_VALID = rvalid_reg;
  assign WR_REJECT = reject_reg;
  assign POWER_STATE = state_reg;
  assign UPLOAD_READY = (wait_reg == 16'h0000);
  assign CLOCKS_ON = (logic_en == VAL_LOGIC_ON);
  assign ANALOG_ON = (state_reg == ST_IDLE) || (state_reg == ST_RUNNING);
  assign DEPTH_8BIT = regs_reg[12][BIT_DEPTH_8];
  assign ROLLING_SHUTTER = seq_mode[BIT_SHUTTER];
  assign TRIGGERED_MODE = seq_mode[BIT_TRIGGERED] && !seq_mode[BIT_SHUTTER];
  assign SLAVE_MODE = seq_mode[BIT_SLAVE] && !seq_mode[BIT_SHUTTER];
  assign SUBSAMPLE_EN = seq_mode[BIT_SUBSAMPLE];
  assign BINNING_EN = seq_mode[BIT_BINNING];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence run_write_s;
    WR_EN && ADDR == ADDR_SEQ_MODE && WDATA[BIT_SEQ_RUN] && state_reg == ST_IDLE && !mode_change;
  endsequence

  run_start_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    run_write_s |-> ##2 state_reg == ST_RUNNING ##2 CAPTURING || !$stable(state_reg))
    else $error("run bit did not start capture");
  run_stop_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_RUNNING && !seq_mode[BIT_SEQ_RUN] |=> state_reg == ST_IDLE ##1 !CAPTURING)
    else $error("clear of run bit did not stop capture");
  mode_lock_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_RUNNING && WR_EN && ADDR == ADDR_SEQ_MODE && mode_change |=>
      WR_REJECT && $stable(seq_mode & MODE_FIELD_MASK))
    else $error("mode change accepted while running");
  shutter_map_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    ROLLING_SHUTTER == seq_mode[1] && !(ROLLING_SHUTTER && (TRIGGERED_MODE || SLAVE_MODE)))
    else $error("shutter field mismatch");
  depth_sel_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    wr_ok && ADDR == ADDR_BLACK_DEPTH |=> DEPTH_8BIT == $past(WDATA[13]))
    else $error("depth select not followed");
  idle_enter_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_IDLE |-> ANALOG_ON && CLOCKS_ON && !CAPTURING)
    else $error("idle state wrong enables");
  wait_count_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $rose(UPLOAD_READY) |-> $past(wait_reg) == 16'h0001)
    else $error("reset wait miscounted");
  clock_off_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_STANDBY2 && logic_en == VAL_OFF |=> state_reg == ST_STANDBY1)
    else $error("logic disable did not reach standby one");
  standby_two_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    state_reg == ST_STANDBY2 |-> &resv_reg && $past(CLOCKS_ON))
    else $error("standby two without uploads");

endmodule : sensor_power_state_upload_sequencer

// ===== testbench/host_reg_writer.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host controller that uploads sensor registers
// ----------------------------------------------------------------
module host_reg_writer
  import pwr_seq_pkg::*;
(
  input wire logic clk, // System clock
  output logic wr_en, // Write strobe
  output logic rd_en, // Read strobe
  output logic [8:0] addr, // Register index
  output logic [15:0] wdata, // Write data
  input wire logic [15:0] rdata, // Read data
  input wire logic wr_reject // Write refused pulse
);
  // Idle levels from time zero
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 9'h000;
    wdata = 16'h0000;
  end

  // One write; released lines carry the inverse so stale values never pass for live ones
  task automatic wr(input logic [8:0] a, input logic [15:0] d, output logic rej);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1 rej = wr_reject;
  endtask : wr

  // One read; data is taken in the cycle after the strobe
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask : rd

  // Ordered list of {address, data} writes
  task automatic upload(input logic [24:0] lst[$]);
    logic rej;
    foreach (lst[i]) wr(lst[i][24:16], lst[i][15:0], rej);
  endtask : upload

  // Clock management on, strictly in this order
  task automatic clock_on();
    upload('{{ADDR_VARIANT_SELECT, 16'h0000}, {ADDR_CLOCK_MGMT, VAL_CLK_DIGITAL}, {ADDR_LOGIC_ENABLE, VAL_LOGIC_ON}});
  endtask : clock_on

  // Reserved uploads with exact values only; depth chosen by caller
  task automatic reserved(input logic d8);
    upload('{{ADDR_GENERAL_BIAS, 16'h008b}, {ADDR_FRONT_END_BIAS, 16'h53c6}, {ADDR_MUX_BIAS, 16'h0844},
      {ADDR_SERIAL_OUT_BIAS, 16'h0086}, {ADDR_BLACK_LEVEL, 16'h4520}, {ADDR_GAIN, 16'h09e5},
      {ADDR_DUMMY_ROWS, 16'h3e04}, {ADDR_LATENCY, 16'h6733}, {ADDR_BLACK_DEPTH, (d8 ? 16'h2000 : 16'h0000)},
      {ADDR_SEQ_TUNE_A, 16'h0bf1}, {ADDR_SEQ_TUNE_B, 16'h0bc3}});
  endtask : reserved

  // Soft power-up in the fixed order
  task automatic power_up();
    upload('{{ADDR_CLOCK_MGMT, 16'h2003}, {ADDR_BIAS_ENABLE, 16'h0001}, {ADDR_COLUMN_MUX, 16'h0003},
      {ADDR_FRONT_END, 16'h0001}, {ADDR_SERIAL_TX, 16'h0007}});
  endtask : power_up

  // Soft power-down, ending with clock management back at digital; clock stop is left to the caller
  task automatic power_down();
    upload('{{ADDR_SERIAL_TX, 16'h0000}, {ADDR_FRONT_END, 16'h0000}, {ADDR_COLUMN_MUX, 16'h0000},
      {ADDR_BIAS_ENABLE, 16'h0000}, {ADDR_CLOCK_MGMT, 16'h2002}});
  endtask : power_down
endmodule : host_reg_writer

// ===== testbench/test_sensor_power_state_upload_sequencer.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Self-checking bench for the power state upload sequencer
// ----------------------------------------------------------------
module test_sensor_power_state_upload_sequencer;
  import pwr_seq_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic trigger = 1'b0;
  logic wr_en, rd_en, rdata_valid, wr_reject, upload_ready, clocks_on, analog_on, depth_8bit;
  logic rolling, triggered, slave, subsample, binning, capturing, overhead, frame_start, rej, d8;
  logic [8:0] addr;
  logic [15:0] wdata, rdata, rd_val, mode;
  logic [2:0] power_state;
  logic [16:0] rnd = 17'd74145;
  int bad_count = 0;
  int checks = 0;

  sensor_power_state_upload_sequencer uut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .WR_EN(wr_en), .RD_EN(rd_en),
    .ADDR(addr), .WDATA(wdata), .TRIGGER(trigger), .RDATA(rdata), .RDATA_VALID(rdata_valid),
    .WR_REJECT(wr_reject), .POWER_STATE(power_state), .UPLOAD_READY(upload_ready), .CLOCKS_ON(clocks_on),
    .ANALOG_ON(analog_on), .DEPTH_8BIT(depth_8bit), .ROLLING_SHUTTER(rolling), .TRIGGERED_MODE(triggered),
    .SLAVE_MODE(slave), .SUBSAMPLE_EN(subsample), .BINNING_EN(binning), .CAPTURING(capturing),
    .FRAME_OVERHEAD(overhead), .FRAME_START(frame_start));
  host_reg_writer host (.clk(clk_sys), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .wr_reject(wr_reject));

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // Next value of the stimulus shift register
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr

  // Expected mode outputs; trigger and slave only count under global shutter
  function automatic logic [4:0] exp_mode(input logic [15:0] m);
    return {m[1], m[4] & ~m[1], m[5] & ~m[1], m[7], m[8]};
  endfunction : exp_mode

  // One comparison
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Let the state register follow the last write
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  // Bounded wait for a frame start pulse
  task automatic wait_frame(input int limit);
    int n;
    n = 0;
    while (frame_start !== 1'b1 && n < limit) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check("frame_start", {15'h0000, frame_start}, 16'h0001);
    check("overhead", {15'h0000, overhead}, 16'h0001);
    @(posedge clk_sys);
    #1;
  endtask : wait_frame

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // Watchdog at 20000 cycles, well beyond the expected run of about 1250 cycles
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1 check("state_rst", {13'h0000, power_state}, 16'h0000);
    host.rd(ADDR_SEQ_MODE, rd_val);
    check("mode_rst", rd_val, 16'h0000);
    check("rd_valid", {15'h0000, rdata_valid}, 16'h0001);
    for (int n = 0; n < 1100 && upload_ready !== 1'b1; n++) @(posedge clk_sys);
    check("upload_ready", {15'h0000, upload_ready}, 16'h0001);
    host.wr(ADDR_BIAS_ENABLE, 16'h0001, rej);
    check("sb1_reject", {15'h0000, rej}, 16'h0001);
    host.clock_on();
    settle();
    check("state_int", {13'h0000, power_state, clocks_on}, 16'h0003);
    host.wr(9'h003, 16'h1234, rej);
    check("unmapped_wr", {15'h0000, rej}, 16'h0001);
    rnd = lfsr(rnd);
    d8 = rnd[0];
    host.reserved(d8);
    settle();
    check("state_sb2", {13'h0000, power_state}, 16'h0002);
    check("depth", {15'h0000, depth_8bit}, {15'h0000, d8});
    host.power_up();
    settle();
    check("state_idle", {12'h000, power_state, analog_on}, 16'h0007);
    // Random mode fields in idle, last one kept global master
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      mode = {rnd[15:0] ^ rnd[16:1]} & (i == 5 ? 16'h0180 : MODE_FIELD_MASK);
      host.wr(ADDR_SEQ_MODE, mode, rej);
      settle();
      check("mode_out", {11'h000, rolling, triggered, slave, subsample, binning}, {11'h000, exp_mode(mode)});
    end
    host.rd(ADDR_SEQ_MODE, rd_val);
    host.wr(ADDR_SEQ_MODE, rd_val | 16'h0001, rej);
    check("run_accept", {15'h0000, rej}, 16'h0000);
    wait_frame(20);
    check("state_run", {12'h000, power_state, capturing}, 16'h0009);
    wait_frame(90);
    host.wr(ADDR_SEQ_MODE, rd_val | 16'h0003, rej);
    check("run_mode_reject", {15'h0000, rej}, 16'h0001);
    check("mode_held", {11'h000, rolling, triggered, slave, subsample, binning}, {11'h000, exp_mode(rd_val)});
    host.wr(ADDR_SEQ_MODE, rd_val, rej);
    settle();
    check("stopped", {12'h000, power_state, capturing}, 16'h0006);
    // Triggered master: run starts but no frame until the trigger rises
    host.wr(ADDR_SEQ_MODE, 16'h0011, rej);
    repeat (20) @(posedge clk_sys);
    check("trig_wait", {12'h000, power_state, capturing}, 16'h0008);
    trigger <= 1'b1;
    wait_frame(10);
    trigger <= 1'b0;
    host.wr(ADDR_SEQ_MODE, 16'h0010, rej);
    settle();
    check("trig_stop", {12'h000, power_state, capturing}, 16'h0006);
    host.power_down();
    settle();
    check("state_down", {12'h000, power_state, analog_on}, 16'h0004);
    host.wr(ADDR_LOGIC_ENABLE, 16'h0000, rej);
    settle();
    check("state_off", {13'h0000, power_state, clocks_on}, 16'h0000);
    end_sim();
  end
endmodule : test_sensor_power_state_upload_sequencer
